// [core/rhf_core.v]
// Host interface and FIFO data path of a reader front end.
// Host is master and drives data_clk; air encoder/decoder sit on the air_* ports, same clock.
//
// What this block does
// - Twelve-byte FIFO at one address, locations 0..11, filled cyclically.
// - Reset direct command empties the FIFO and its counter.
// - FIFO status low nibble reports stored bytes minus one.
// - Twelve-bit TX byte length plus four partial bits decide the end-of-frame.
// - Overflow flag, FIFO status bit 4, when loaded while full.
// - Level-low flag, bit 5, during transmit when three bytes remain.
// - Level-high flag, bit 6, at nine bytes; drives receive FIFO interrupt.
// - Interrupt when FIFO runs low in transmit or high in receive.
// - Transmit starts by itself on the first FIFO byte written.
// - Parallel: data7 rising with clock high is start, resets interface.
// - Parallel: data7 falling with clock high is simple stop.
// - Parallel: data7 rise then fall with clock low is continuous stop.
// - Start-of-frame sets status bit 6; short frames interrupt at end.
// - Long received frames interrupt when the ninth byte enters.
// - Receive failures set framing or checksum error status flags.
// - TX start sets bit 7; five-plus byte frames also interrupt at three.
// - Straps sampled after reset select parallel or one of two serial modes.
// - Serial: status clears one read clock after its read; parallel at stop.
// - Serial without select: data-in edges with clock high start and stop.
// - First word: bit7 command, bit6 read, bit5 continuous, bits4..0 code.
// - Continuous mode increments address per byte; single mode takes one.
`timescale 1ns/1ps
`default_nettype none
`include "rhf_regs.vh"

module rhf_core #(
	parameter DEPTH = 12
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire        data_clk,
	input  wire [7:0]  io_in,
	output wire [7:0]  io_out,
	output wire [7:0]  io_oe,
	output wire        irq,
	output wire [7:0]  air_tx_byte,
	output wire        air_tx_valid,
	input  wire        air_tx_ready,
	output wire        air_tx_eof,
	output wire [3:0]  air_tx_tail_bits,
	input  wire [7:0]  air_rx_byte,
	input  wire        air_rx_valid,
	output wire        air_rx_ready,
	input  wire        air_rx_sof,
	input  wire        air_rx_end,
	input  wire        air_rx_frame_err,
	input  wire        air_rx_crc_err
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_ADDR = 4'b0010;
	localparam [3:0] ST_DATA = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;
	localparam [3:0] LVL_SPARE = DEPTH - 1;

	// ----------------------------------------
	// Pin synchronisers and edge detect
	// ----------------------------------------
	reg [1:0] ck_sync_r;
	reg       ck_d_r;
	reg [7:0] io_s1_r;
	reg [7:0] io_s2_r;
	reg       d7_d_r;
	reg       ss_d_r;

	always @(posedge clock)
	begin
		if (!nrst)
		begin
			ck_sync_r <= 2'h0;
			ck_d_r    <= 1'b0;
			io_s1_r   <= 8'h00;
			io_s2_r   <= 8'h00;
			d7_d_r    <= 1'b0;
			ss_d_r    <= 1'b1;
		end
		else
		begin
			ck_sync_r <= {ck_sync_r[0], data_clk};
			ck_d_r    <= ck_sync_r[1];
			io_s1_r   <= io_in;
			io_s2_r   <= io_s1_r;
			d7_d_r    <= io_s2_r[7];
			ss_d_r    <= io_s2_r[4];
		end
	end

	wire ck      = ck_sync_r[1];
	wire ck_rise = ck & ~ck_d_r;
	wire ck_fall = ~ck & ck_d_r;
	wire d7      = io_s2_r[7];
	wire d7_rise = d7 & ~d7_d_r;
	wire d7_fall = ~d7 & d7_d_r;
	wire ss_rise = io_s2_r[4] & ~ss_d_r;
	wire ss_fall = ~io_s2_r[4] & ss_d_r;

	// ----------------------------------------
	// Mode straps
	// ----------------------------------------
	reg [1:0] strap_cnt_r;
	reg       strap_done_r;
	reg       par_mode_r;
	reg       ss_mode_r;

	always @(posedge clock)
	begin
		if (!nrst)
		begin
			strap_cnt_r  <= 2'h0;
			strap_done_r <= 1'b0;
			par_mode_r   <= 1'b1;
			ss_mode_r    <= 1'b0;
		end
		else if (!strap_done_r)
		begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == `RHF_STRAP_WAIT)
			begin
				strap_done_r <= 1'b1;
				par_mode_r   <= (io_s2_r[2:0] == 3'h0) || (io_s2_r[2:0] == 3'h7);
				ss_mode_r    <= (io_s2_r[2:0] != 3'h0) && (io_s2_r[2:0] != 3'h7)
					&& io_s2_r[1];
			end
		end
	end

	// ----------------------------------------
	// Start and stop conditions
	// ----------------------------------------
	reg  cstop_arm_r;
	wire start_ev = strap_done_r & (ss_mode_r ? ss_fall : (d7_rise & ck));
	wire sstop_ev = strap_done_r & (ss_mode_r ? ss_rise : (d7_fall & ck));
	wire cstop_ev = strap_done_r & par_mode_r & d7_fall & ~ck & cstop_arm_r;
	wire stop_ev  = sstop_ev | cstop_ev;

	always @(posedge clock)
	begin
		if (!nrst)
			cstop_arm_r <= 1'b0;
		else if (d7_fall || start_ev)
			cstop_arm_r <= 1'b0;
		else if (par_mode_r && d7_rise && !ck)
			cstop_arm_r <= 1'b1;
	end

	// ----------------------------------------
	// Word engine
	// ----------------------------------------
	reg [3:0] st_r;
	reg [2:0] bit_cnt_r;
	reg [7:0] in_sh_r;
	reg [4:0] adr_r;
	reg       rd_r;
	reg       cont_r;
	reg [7:0] out_sh_r;
	reg [7:0] io_out_r;
	reg [7:0] io_oe_r;
	reg [7:0] rd_mux;

	wire [7:0] byte_in   = par_mode_r ? io_s2_r : {in_sh_r[6:0], d7};
	wire       busy      = st_r[1] | st_r[2];
	wire       byte_done = ck_rise & busy & (par_mode_r | (bit_cnt_r == 3'h7));
	wire       addr_word = byte_done & st_r[1];
	wire       cmd_ev    = addr_word & byte_in[7];
	wire [4:0] ld_adr    = st_r[1] ? byte_in[4:0] : adr_r + 5'h01;
	wire       ld_read   = byte_done & ((st_r[1] & ~byte_in[7] & byte_in[6])
		| (st_r[2] & rd_r & cont_r));
	wire       wr_ev     = byte_done & st_r[2] & ~rd_r;
	wire       reset_cmd = cmd_ev & (byte_in[4:0] == `RHF_CMD_RESET);

	always @(posedge clock)
	begin
		if (!nrst || stop_ev)
		begin
			st_r      <= ST_IDLE;
			bit_cnt_r <= 3'h0;
			rd_r      <= 1'b0;
			cont_r    <= 1'b0;
			adr_r     <= 5'h00;
			in_sh_r   <= 8'h00;
			out_sh_r  <= 8'h00;
			io_out_r  <= 8'h00;
			io_oe_r   <= 8'h00;
		end
		else if (start_ev)
		begin
			st_r      <= ST_ADDR;
			bit_cnt_r <= 3'h0;
			io_oe_r   <= 8'h00;
		end
		else
		begin
			if (ck_rise && busy)
			begin
				in_sh_r   <= byte_in;
				bit_cnt_r <= bit_cnt_r + 3'h1;
			end
			if (addr_word)
			begin
				rd_r   <= byte_in[6];
				cont_r <= byte_in[5];
				adr_r  <= byte_in[4:0];
				st_r   <= byte_in[7] ? ST_DONE : ST_DATA;
			end
			else if (byte_done && st_r[2])
			begin
				if (cont_r)
					adr_r <= adr_r + 5'h01;
				else
					st_r <= ST_DONE;
			end
			if (ld_read)
			begin
				out_sh_r <= rd_mux;
				io_oe_r  <= par_mode_r ? 8'hFF : 8'h40;
				if (par_mode_r)
					io_out_r <= rd_mux;
			end
			else if (byte_done && st_r[2] && rd_r && !cont_r)
				io_oe_r <= 8'h00;
			if (ck_fall && !par_mode_r && st_r[2] && rd_r)
			begin
				io_out_r[6] <= out_sh_r[7];
				out_sh_r    <= {out_sh_r[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// FIFO and its flags
	// ----------------------------------------
	reg  [7:0]  irq_stat_r;
	reg  [7:0]  irq_mask_r;
	reg  [7:0]  len_hi_r;
	reg  [7:0]  len_lo_r;
	reg         ovf_r;
	reg         tx_act_r;
	reg         rx_act_r;
	reg  [11:0] sent_r;
	reg  [3:0]  lvl_d_r;
	reg  [7:0]  tx_byte_r;
	reg         tx_valid_r;
	reg         tx_eof_r;
	reg         rx_ready_r;
	reg         irq_r;
	reg         stat_rd_r;
	reg         stat_arm_r;
	wire        f_in_ready;
	wire        f_out_valid;
	wire [7:0]  f_out_data;
	wire [3:0]  lvl;

	wire [11:0] tx_len    = {len_hi_r, len_lo_r[7:4]};
	wire        host_push = wr_ev & (adr_r == `RHF_ADR_FIFO);
	wire        host_pop  = ld_read & (ld_adr == `RHF_ADR_FIFO) & f_out_valid & ~tx_act_r;
	wire        f_in_val  = host_push | air_rx_valid;
	wire [7:0]  f_in_dat  = host_push ? byte_in : air_rx_byte;
	wire        tx_slot   = ~tx_valid_r | air_tx_ready;
	wire        tx_pop    = tx_act_r & f_out_valid & tx_slot & (sent_r != tx_len);
	wire        tx_done   = tx_act_r & (sent_r == tx_len) & tx_slot;
	wire        tx_start  = host_push & ~tx_act_r & ~rx_act_r;
	wire        lost      = (f_in_val & ~f_in_ready) | (host_push & air_rx_valid);
	wire [3:0]  lvl_field = (lvl == 4'h0) ? 4'h0 : lvl - 4'h1;
	wire        lvl_high  = (lvl >= `RHF_LVL_HIGH);
	wire        lvl_low   = tx_act_r & (lvl <= `RHF_LVL_LOW);
	wire [7:0]  fifo_stat = {1'b0, lvl_high, lvl_low, ovf_r, lvl_field};
	wire        tx_fifo_ev = tx_act_r & (tx_len >= `RHF_TX_FIFO_IRQ_MIN)
		& (lvl == `RHF_LVL_LOW) & (lvl_d_r == `RHF_LVL_LOW_PREV);
	wire        rx_fifo_ev = rx_act_r & (lvl == `RHF_LVL_HIGH)
		& (lvl_d_r == `RHF_LVL_HIGH_PREV);
	wire        fifo_ev   = tx_fifo_ev | rx_fifo_ev;
	wire        irq_ev    = fifo_ev | tx_done | air_rx_end | air_rx_frame_err | air_rx_crc_err;
	wire        stat_clr  = stat_arm_r & (par_mode_r ? stop_ev : ck_rise);

	rhf_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH),
		.CW    (4)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.clear     (reset_cmd),
		.in_valid  (f_in_val),
		.in_data   (f_in_dat),
		.in_ready  (f_in_ready),
		.out_valid (f_out_valid),
		.out_data  (f_out_data),
		.out_ready (tx_act_r ? tx_pop : host_pop),
		.level     (lvl)
	);

	always @*
	begin
		case (ld_adr)
			`RHF_ADR_IRQ_STAT:  rd_mux = irq_stat_r;
			`RHF_ADR_IRQ_MASK:  rd_mux = irq_mask_r;
			`RHF_ADR_FIFO_STAT: rd_mux = fifo_stat;
			`RHF_ADR_TX_LEN_HI: rd_mux = len_hi_r;
			`RHF_ADR_TX_LEN_LO: rd_mux = len_lo_r;
			`RHF_ADR_FIFO:      rd_mux = f_out_valid ? f_out_data : 8'h00;
			default:            rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Registers, transmit and receive control
	// ----------------------------------------
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			irq_stat_r <= `RHF_IRQ_STAT_RST;
			irq_mask_r <= `RHF_IRQ_MASK_RST;
			len_hi_r   <= `RHF_TX_LEN_RST;
			len_lo_r   <= `RHF_TX_LEN_RST;
			ovf_r      <= 1'b0;
			tx_act_r   <= 1'b0;
			rx_act_r   <= 1'b0;
			sent_r     <= 12'h000;
			lvl_d_r    <= 4'h0;
			tx_byte_r  <= 8'h00;
			tx_valid_r <= 1'b0;
			tx_eof_r   <= 1'b0;
			rx_ready_r <= 1'b0;
			irq_r      <= 1'b0;
			stat_rd_r  <= 1'b0;
			stat_arm_r <= 1'b0;
		end
		else
		begin
			lvl_d_r    <= lvl;
			rx_ready_r <= (lvl < LVL_SPARE);
			tx_eof_r   <= tx_done;
			if (wr_ev && adr_r == `RHF_ADR_IRQ_MASK)
				irq_mask_r <= byte_in;
			if (wr_ev && adr_r == `RHF_ADR_TX_LEN_HI)
				len_hi_r <= byte_in;
			if (wr_ev && adr_r == `RHF_ADR_TX_LEN_LO)
				len_lo_r <= byte_in;
			if (lost)
				ovf_r <= 1'b1;
			else if (reset_cmd)
				ovf_r <= 1'b0;
			if (tx_pop)
			begin
				tx_byte_r  <= f_out_data;
				tx_valid_r <= 1'b1;
			end
			else if (air_tx_ready)
				tx_valid_r <= 1'b0;
			if (reset_cmd || tx_done)
			begin
				tx_act_r <= 1'b0;
				sent_r   <= 12'h000;
			end
			else
			begin
				if (tx_start)
					tx_act_r <= 1'b1;
				if (tx_pop)
					sent_r <= sent_r + 12'h001;
			end
			if (reset_cmd || air_rx_end)
				rx_act_r <= 1'b0;
			else if (air_rx_sof)
				rx_act_r <= 1'b1;
			if (ld_read && ld_adr == `RHF_ADR_IRQ_STAT)
				stat_rd_r <= 1'b1;
			else if (byte_done && st_r[2] && rd_r)
				stat_rd_r <= 1'b0;
			if (byte_done && st_r[2] && rd_r && stat_rd_r)
				stat_arm_r <= 1'b1;
			else if (stat_clr)
				stat_arm_r <= 1'b0;
			irq_stat_r <= stat_clr ? 8'h00 : irq_stat_r;
			if (tx_start || tx_done)
				irq_stat_r[`RHF_IRQ_TX_BIT] <= 1'b1;
			if (air_rx_sof)
				irq_stat_r[`RHF_IRQ_RX_BIT] <= 1'b1;
			if (fifo_ev)
				irq_stat_r[`RHF_IRQ_FIFO_BIT] <= 1'b1;
			if (air_rx_crc_err)
				irq_stat_r[`RHF_IRQ_CRC_BIT] <= 1'b1;
			if (air_rx_frame_err)
				irq_stat_r[`RHF_IRQ_FRAME_BIT] <= 1'b1;
			if (irq_ev)
				irq_r <= 1'b1;
			else if (stat_clr)
				irq_r <= 1'b0;
		end
	end

	assign io_out           = io_out_r;
	assign io_oe            = io_oe_r;
	assign irq              = irq_r;
	assign air_tx_byte      = tx_byte_r;
	assign air_tx_valid     = tx_valid_r;
	assign air_tx_eof       = tx_eof_r;
	assign air_tx_tail_bits = len_lo_r[3:0];
	assign air_rx_ready     = rx_ready_r;

endmodule

`default_nettype wire

// [core/rhf_regs.vh]
// Register map, field positions, reset values and counts of the reader FIFO host block.
// Included by rhf_core.v; definitions only.
`ifndef RHF_REGS_VH
`define RHF_REGS_VH

// ----------------------------------------
// Register offsets (5-bit address field)
// ----------------------------------------
`define RHF_ADR_IRQ_STAT 5'h0C
`define RHF_ADR_IRQ_MASK 5'h0D
`define RHF_ADR_FIFO_STAT 5'h1C
`define RHF_ADR_TX_LEN_HI 5'h1D
`define RHF_ADR_TX_LEN_LO 5'h1E
`define RHF_ADR_FIFO 5'h1F

// ----------------------------------------
// Direct commands
// ----------------------------------------
`define RHF_CMD_RESET 5'h0F

// ----------------------------------------
// Interrupt cause bits
// ----------------------------------------
`define RHF_IRQ_TX_BIT 7
`define RHF_IRQ_RX_BIT 6
`define RHF_IRQ_FIFO_BIT 5
`define RHF_IRQ_CRC_BIT 4
`define RHF_IRQ_FRAME_BIT 2

// ----------------------------------------
// FIFO status fields
// ----------------------------------------
`define RHF_FST_OVF_BIT 4
`define RHF_FST_LOW_BIT 5
`define RHF_FST_HIGH_BIT 6
`define RHF_LVL_LOW 4'h3
`define RHF_LVL_LOW_PREV 4'h4
`define RHF_LVL_HIGH 4'h9
`define RHF_LVL_HIGH_PREV 4'h8
`define RHF_TX_FIFO_IRQ_MIN 12'h005

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define RHF_IRQ_STAT_RST 8'h00
`define RHF_IRQ_MASK_RST 8'h00
`define RHF_TX_LEN_RST 8'h00
`define RHF_STRAP_WAIT 2'h3

`endif

// [core/rhf_fifo.v]
// Byte FIFO with valid/ready on both sides, level output and synchronous clear.
// Same clock as its user; storage in flip-flops addressed by index.
`timescale 1ns/1ps
`default_nettype none

module rhf_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 12,
	parameter CW    = 4
) (
	input  wire             clock,
	input  wire             nrst,
	input  wire             clear,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	output wire             out_valid,
	output wire [WIDTH-1:0] out_data,
	input  wire             out_ready,
	output wire [CW-1:0]    level
);

	localparam [CW-1:0] LAST = DEPTH - 1;
	localparam [CW-1:0] FULL = DEPTH;

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [CW-1:0]    wr_ptr_r;
	reg [CW-1:0]    rd_ptr_r;
	reg [CW-1:0]    cnt_r;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_r != FULL);
	assign out_valid = (cnt_r != {CW{1'b0}});
	assign out_data  = mem_r[rd_ptr_r];
	assign level     = cnt_r;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1)
		begin : g_mem
			always @(posedge clock)
			begin
				if (push && wr_ptr_r == gi)
					mem_r[gi] <= in_data;
			end
		end
	endgenerate

	always @(posedge clock)
	begin
		if (!nrst || clear)
		begin
			wr_ptr_r <= {CW{1'b0}};
			rd_ptr_r <= {CW{1'b0}};
			cnt_r    <= {CW{1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == LAST) ? {CW{1'b0}} : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == LAST) ? {CW{1'b0}} : rd_ptr_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

endmodule

`default_nettype wire

// [tb/rhf_host_model.sv]
// Host controller model: serial link master without select, owner of the link clock.
// Straps on io_in[2:0] held at the no-select serial pattern; link clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none

module rhf_host_model (
	output logic            data_clk,
	output logic      [7:0] io_in,
	input  wire logic [7:0] io_out
);
	initial
	begin
		data_clk = 1'b0;
		io_in    = 8'h04;
	end

	// Start: data in rises while link clock high
	task start_c;
		#13 io_in[7] = 1'b0;
		#100 data_clk = 1'b1;
		#100 io_in[7] = 1'b1;
		#100;
	endtask

	// Stop: data in falls while link clock high, then clock stands still
	task stop_c;
		data_clk = 1'b0;
		#50 io_in[7] = 1'b1;
		#50 data_clk = 1'b1;
		#100 io_in[7] = 1'b0;
		#100 data_clk = 1'b0;
	endtask

	// MSB first; data moves only while clock low; MISO taken late in high phase
	task xfer(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
		begin
			data_clk = 1'b0;
			#50 io_in[7] = w[i];
			#50 data_clk = 1'b1;
			#100 r[i] = io_out[6];
		end
	endtask
endmodule
`default_nettype wire

// [tb/rhf_core_chk.sv]
// Port-level checks of the reader FIFO host block.
// Bound into every rhf_core instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module rhf_core_chk (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic [7:0] io_oe,
	input wire logic       irq,
	input wire logic [7:0] air_tx_byte,
	input wire logic       air_tx_valid,
	input wire logic       air_tx_ready,
	input wire logic       air_tx_eof,
	input wire logic       air_rx_valid,
	input wire logic       air_rx_ready,
	input wire logic       air_rx_sof,
	input wire logic       air_rx_end
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Received bytes since start of frame
	// ----------------------------------------
	logic [3:0] rx_cnt_r;
	logic [3:0] rx_cnt_nxt;
	assign rx_cnt_nxt = air_rx_sof ? 4'h0 :
		(air_rx_valid && air_rx_ready && rx_cnt_r != 4'hF) ? rx_cnt_r + 4'h1 : rx_cnt_r;
	always_ff @(posedge clock)
		if (!nrst)
			rx_cnt_r <= 4'h0;
		else
			rx_cnt_r <= rx_cnt_nxt;

	sequence tx_stall_s;
		air_tx_valid && !air_tx_ready;
	endsequence
	sequence ninth_push_s;
		rx_cnt_r == 4'h8 && air_rx_valid && air_rx_ready;
	endsequence

	reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> io_oe == 8'h00 && !irq
		&& !air_tx_valid && !air_tx_eof) else $error("outputs active after reset");
	tx_hold_a: assert property (tx_stall_s |=> air_tx_valid && $stable(air_tx_byte))
		else $error("tx byte changed while stalled");
	eof_pulse_a: assert property (air_tx_eof |=> !air_tx_eof)
		else $error("end of frame longer than one cycle");
	eof_idle_a: assert property (air_tx_eof |-> !air_tx_valid)
		else $error("end of frame with byte pending");
	eof_irq_a: assert property (air_tx_eof |-> ##[0:4] irq)
		else $error("no interrupt at transmit end");
	rx_end_irq_a: assert property (air_rx_end |-> ##[1:4] irq)
		else $error("no interrupt at receive end");
	ninth_byte_a: assert property (ninth_push_s |-> ##[1:4] irq)
		else $error("no interrupt at ninth received byte");
	oe_shape_a: assert property (io_oe inside {8'h00, 8'h40, 8'hFF})
		else $error("unexpected output enable pattern");
endmodule

bind rhf_core rhf_core_chk i_rhf_core_chk (
	.clock(clock), .nrst(nrst), .io_oe(io_oe), .irq(irq),
	.air_tx_byte(air_tx_byte), .air_tx_valid(air_tx_valid), .air_tx_ready(air_tx_ready),
	.air_tx_eof(air_tx_eof), .air_rx_valid(air_rx_valid), .air_rx_ready(air_rx_ready),
	.air_rx_sof(air_rx_sof), .air_rx_end(air_rx_end)
);
`default_nettype wire

// [tb/rhf_core_tb.sv]
// Self-checking bench of the reader FIFO host block: register reads, transmit and receive.
// Host model is the serial link master; air sides driven here on the 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end

module rhf_core_tb;
	logic        clock, nrst, air_tx_ready, drain;
	logic        air_rx_valid, air_rx_sof, air_rx_end, air_rx_frame_err, air_rx_crc_err;
	logic [7:0]  air_rx_byte, rd_v, ev, tv;
	logic [1:0]  cyc;
	logic [31:0] seed;
	logic [7:0]  exp_q[$], tx_q[$], rx_q[$], wq[$];
	int          miscompares, checked;
	event        got;
	wire         data_clk, irq, air_tx_valid, air_tx_eof, air_rx_ready;
	wire  [7:0]  io_in, io_out, io_oe, air_tx_byte;
	wire  [3:0]  air_tx_tail_bits;

	rhf_core i_rhf_core (
		.clock(clock), .nrst(nrst), .data_clk(data_clk), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe), .irq(irq), .air_tx_byte(air_tx_byte), .air_tx_valid(air_tx_valid),
		.air_tx_ready(air_tx_ready), .air_tx_eof(air_tx_eof),
		.air_tx_tail_bits(air_tx_tail_bits), .air_rx_byte(air_rx_byte),
		.air_rx_valid(air_rx_valid), .air_rx_ready(air_rx_ready), .air_rx_sof(air_rx_sof),
		.air_rx_end(air_rx_end), .air_rx_frame_err(air_rx_frame_err),
		.air_rx_crc_err(air_rx_crc_err)
	);
	rhf_host_model i_rhf_host_model (.data_clk(data_clk), .io_in(io_in), .io_out(io_out));

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ----------------------------------------
	// Result watchers and encoder ready pacing
	// ----------------------------------------
	always @(got)
	begin
		ev = exp_q.pop_front();
		`CHK("host read", ev, rd_v)
	end
	always @(posedge clock)
		if (nrst && air_tx_valid && air_tx_ready)
		begin
			tv = tx_q.pop_front();
			`CHK("air tx byte", tv, air_tx_byte)
		end
	always @(posedge clock)
	begin
		#2;
		cyc = cyc + 2'h1;
		air_tx_ready = drain & (cyc != 2'h0);
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task conclude;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task hrd(input logic [7:0] w, input int n);
		logic [7:0] r;
		i_rhf_host_model.start_c();
		i_rhf_host_model.xfer(w, r);
		repeat (n)
		begin
			i_rhf_host_model.xfer(8'h00, r);
			rd_v = r;
			-> got;
		end
		i_rhf_host_model.stop_c();
	endtask

	task hwr(input logic [7:0] w);
		logic [7:0] r;
		i_rhf_host_model.start_c();
		i_rhf_host_model.xfer(w, r);
		while (wq.size() > 0)
			i_rhf_host_model.xfer(wq.pop_front(), r);
		i_rhf_host_model.stop_c();
	endtask

	task rx_frame(input int n);
		@(posedge clock) #2 air_rx_sof = 1'b1;
		@(posedge clock) #2 air_rx_sof = 1'b0;
		repeat (n)
		begin
			@(posedge clock) #2 seed = xs(seed);
			air_rx_byte  = seed[7:0];
			air_rx_valid = 1'b1;
			rx_q.push_back(seed[7:0]);
			@(posedge clock) #2 air_rx_valid = 1'b0;
		end
		@(posedge clock) #2 {air_rx_crc_err, air_rx_frame_err} = 2'b11;
		@(posedge clock) #2 {air_rx_crc_err, air_rx_frame_err} = 2'b00;
		air_rx_end = 1'b1;
		@(posedge clock) #2 air_rx_end = 1'b0;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int i;
		{nrst, drain} = 2'h0;
		{air_rx_valid, air_rx_sof, air_rx_end, air_rx_frame_err, air_rx_crc_err} = 5'h00;
		air_rx_byte = 8'h00;
		cyc         = 2'h0;
		seed        = 32'h0000_B623;
		miscompares = 0;
		checked     = 0;
		repeat (16) @(posedge clock);
		#2 nrst = 1'b1;
		repeat (16) @(posedge clock);
		exp_q = {8'h00, 8'h00, 8'h00};
		hrd(8'h7C, 3);
		// Thirteen-byte frame into a stalled encoder, one byte too many
		wq = {8'h00, 8'hD5};
		for (i = 0; i < 14; i++)
		begin
			seed = xs(seed);
			if (i < 13)
				tx_q.push_back(seed[7:0]);
			wq.push_back(seed[7:0]);
			if (i == 0)
				hwr(8'h3D);
			else
				hwr(8'h1F);
		end
		repeat (8) @(posedge clock);
		#2;
		`CHK("irq after load", 1'b0, irq)
		`CHK("tail bits", 4'h5, air_tx_tail_bits)
		exp_q = {8'h5B};
		hrd(8'h5C, 1);
		exp_q = {8'h80, 8'h00};
		hrd(8'h6C, 2);
		repeat (8) @(posedge clock);
		#2;
		`CHK("irq cleared", 1'b0, irq)
		drain = 1'b1;
		i = 0;
		while (air_tx_eof !== 1'b1 && i < 2000)
		begin
			@(posedge clock);
			#1 i++;
		end
		if (i == 2000)
		begin
			miscompares++;
			conclude();
		end
		`CHK("tx bytes left", 0, tx_q.size())
		repeat (8) @(posedge clock);
		#2;
		`CHK("irq at tx end", 1'b1, irq)
		exp_q = {8'hA0, 8'h00};
		hrd(8'h6C, 2);
		repeat (8) @(posedge clock);
		#2;
		`CHK("irq cleared after tx", 1'b0, irq)
		exp_q = {8'h10};
		hrd(8'h5C, 1);
		hwr(8'h8F);
		exp_q = {8'h00};
		hrd(8'h5C, 1);
		// Long received frame with both error flags
		rx_frame(10);
		repeat (8) @(posedge clock);
		#2;
		`CHK("irq after receive", 1'b1, irq)
		exp_q = {8'h74, 8'h00};
		hrd(8'h6C, 2);
		exp_q = {8'h49};
		hrd(8'h5C, 1);
		exp_q = rx_q;
		repeat (10)
			hrd(8'h5F, 1);
		exp_q = {8'h00};
		hrd(8'h5C, 1);
		conclude();
	end
endmodule
`default_nettype wire
